// ---- logic/sdo_defines.vh ----
`ifndef SDO_DEFINES_VH
`define SDO_DEFINES_VH
// Register indices; byte address is four times the index
`define SDO_IDX_N_LOW 8'h24
`define SDO_IDX_PD_DELAY 8'h25
`define SDO_IDX_DEN_HIGH 8'h26
`define SDO_IDX_DEN_LOW 8'h27
`define SDO_IDX_SEED_HIGH 8'h28
`define SDO_IDX_SEED_LOW 8'h29
`define SDO_IDX_NUM_HIGH 8'h2a
`define SDO_IDX_NUM_LOW 8'h2b
`define SDO_IDX_PWR_MOD 8'h2c
`define SDO_IDX_B_PWR_A_SEL 8'h2d
`define SDO_IDX_N_HIGH 8'h22
// Reset values
`define SDO_RST_N_LOW 16'h0046
`define SDO_RST_PD_DELAY 16'h0400
`define SDO_RST_DEN_HIGH 16'hfd51
`define SDO_RST_DEN_LOW 16'hda80
`define SDO_RST_ZERO 16'h0000
`define SDO_RST_PWR_MOD 16'h1fa3
`define SDO_RST_B_PWR_A_SEL 16'h001f
`define SDO_RST_N_HIGH 16'h0000
// Writable bit masks; other bits are reserved
`define SDO_MASK_FULL 16'hffff
`define SDO_MASK_PD_DELAY 16'h3f00
`define SDO_MASK_PWR_MOD 16'h3fe7
`define SDO_MASK_B_PWR_A_SEL 16'h183f
`define SDO_MASK_N_HIGH 16'h0007
// Field positions
`define SDO_DLY_SEL_MSB 13
`define SDO_DLY_SEL_LSB 8
`define SDO_A_PWR_MSB 13
`define SDO_A_PWR_LSB 8
`define SDO_B_PD_BIT 7
`define SDO_A_PD_BIT 6
`define SDO_MOD_RSTN_BIT 5
`define SDO_ORDER_MSB 2
`define SDO_ORDER_LSB 0
`define SDO_A_SEL_MSB 12
`define SDO_A_SEL_LSB 11
`define SDO_B_PWR_MSB 5
`define SDO_B_PWR_LSB 0
`define SDO_N_HIGH_MSB 2
// Delay select offset added before the times-four scaling
`define SDO_DLY_BIAS 8'd3
// AXI responses
`define SDO_RESP_OKAY 2'b00
`define SDO_RESP_SLVERR 2'b10
`endif

// ---- logic/sdo_reg16.v ----
`timescale 1ns/10ps
// One 16-bit register with masked write; reserved bits held at zero
module sdo_reg16 #(
  parameter [15:0] RST = 16'h0000,
  parameter [15:0] MASK = 16'hffff
) (
  input wire aclk,
  input wire aresetn,
  input wire we,
  input wire [15:0] wdata,
  input wire [1:0] wstrb,
  output reg [15:0] q_r
);
  wire [15:0] lane;
  wire [15:0] q_nxt;
  assign lane = {{8{wstrb[1]}}, {8{wstrb[0]}}} & MASK;
  assign q_nxt = (q_r & ~lane) | (wdata & lane);
  always @(posedge aclk)
  begin
    if (!aresetn)
      q_r <= RST & MASK;
    else if (we)
      q_r <= q_nxt;
  end
endmodule // sdo_reg16

// ---- logic/sdo_regs.v ----
`timescale 1ns/10ps
`include "sdo_defines.vh"
// Contract
// - N divider low word at 0x24, read/write, resets to 0x46.
// - Detector delay select in 0x25 bits 13-8, reset 4; delay (sel+3)*4 VCO cycles.
// - 32-bit denominator: high half 0x26 reset 0xfd51, low half 0x27 reset 0xda80.
// - 32-bit numerator: high half 0x2a, low half 0x2b, both reset zero.
// - 32-bit seed in 0x28/0x29, reset zero, loaded as modulator start state.
// - Output A power level in 0x2c bits 13-8, reset 0x1f, 0 min 63 max.
// - Output B power level in 0x2d bits 5-0, reset 0x1f, 0 min 63 max.
// - Output B powered down while 0x2c bit 7 is one; resets to one.
// - Output A powered down while 0x2c bit 6 is one; resets to zero.
// - Modulator held in reset while 0x2c bit 5 is zero; resets to one.
// - Modulator order from 0x2c bits 2-0, reset 3.
// - Output A source select in 0x2d bits 12-11, no defined reset.
// - N divider is 19 bits; upper three bits live in a separate register.
module sdo_regs (
  input wire aclk,
  input wire aresetn,
  input wire [9:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [9:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [18:0] n_divider_r,
  output reg [5:0] detector_delay_select_r,
  output reg [7:0] detector_delay_quads_r,
  output reg [31:0] fraction_denominator_r,
  output reg [31:0] fraction_numerator_r,
  output reg [31:0] modulator_seed_r,
  output reg seed_load_r,
  output reg modulator_reset_r,
  output reg [2:0] modulator_order_r,
  output reg [5:0] out_a_power_level_r,
  output reg [5:0] out_b_power_level_r,
  output reg out_a_power_down_r,
  output reg out_b_power_down_r,
  output reg [1:0] out_a_source_select_r
);
  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order, held until both
  reg [9:0] awaddr_r;
  reg aw_held_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg w_held_r;
  wire aw_take;
  wire w_take;
  wire do_write;
  wire [7:0] widx;
  wire wmapped;
  reg [10:0] we;

  function [7:0] word_index;
    input [9:0] addr;
    begin
      word_index = addr[9:2];
    end
  endfunction

  function is_mapped;
    input [7:0] idx;
    begin
      is_mapped = (idx == `SDO_IDX_N_HIGH) || ((idx >= `SDO_IDX_N_LOW) && (idx <= `SDO_IDX_B_PWR_A_SEL));
    end
  endfunction

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  // Write lands once both halves are held, never while a response is pending
  assign do_write = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign widx = word_index(awaddr_r);
  assign wmapped = is_mapped(widx);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 10'h000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SDO_RESP_OKAY;
    end
    else
    begin
      // Readies fall after a take and stay low until the response is accepted
      s_axi_awready <= ~aw_held_r & ~aw_take & ~s_axi_bvalid;
      s_axi_wready <= ~w_held_r & ~w_take & ~s_axi_bvalid;
      if (aw_take)
      begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wmapped ? `SDO_RESP_OKAY : `SDO_RESP_SLVERR;
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always @*
  begin
    we = 11'h000;
    if (do_write)
    begin
      case (widx)
        `SDO_IDX_N_LOW: we[0] = 1'b1;
        `SDO_IDX_PD_DELAY: we[1] = 1'b1;
        `SDO_IDX_DEN_HIGH: we[2] = 1'b1;
        `SDO_IDX_DEN_LOW: we[3] = 1'b1;
        `SDO_IDX_SEED_HIGH: we[4] = 1'b1;
        `SDO_IDX_SEED_LOW: we[5] = 1'b1;
        `SDO_IDX_NUM_HIGH: we[6] = 1'b1;
        `SDO_IDX_NUM_LOW: we[7] = 1'b1;
        `SDO_IDX_PWR_MOD: we[8] = 1'b1;
        `SDO_IDX_B_PWR_A_SEL: we[9] = 1'b1;
        `SDO_IDX_N_HIGH: we[10] = 1'b1;
        default: we = 11'h000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  wire [15:0] n_low_q;
  wire [15:0] pd_delay_q;
  wire [15:0] den_high_q;
  wire [15:0] den_low_q;
  wire [15:0] seed_high_q;
  wire [15:0] seed_low_q;
  wire [15:0] num_high_q;
  wire [15:0] num_low_q;
  wire [15:0] pwr_mod_q;
  wire [15:0] b_pwr_a_sel_q;
  wire [15:0] n_high_q;

  sdo_reg16 #(.RST(`SDO_RST_N_LOW), .MASK(`SDO_MASK_FULL)) u_n_low (
    .aclk(aclk), .aresetn(aresetn), .we(we[0]), .wdata(wdata_r[15:0]), .wstrb(wstrb_r[1:0]), .q_r(n_low_q)
  );
  sdo_reg16 #(.RST(`SDO_RST_PD_DELAY), .MASK(`SDO_MASK_PD_DELAY)) u_pd_delay (
    .aclk(aclk), .aresetn(aresetn), .we(we[1]), .wdata(wdata_r[15:0]), .wstrb(wstrb_r[1:0]), .q_r(pd_delay_q)
  );
  sdo_reg16 #(.RST(`SDO_RST_DEN_HIGH), .MASK(`SDO_MASK_FULL)) u_den_high (
    .aclk(aclk), .aresetn(aresetn), .we(we[2]), .wdata(wdata_r[15:0]), .wstrb(wstrb_r[1:0]), .q_r(den_high_q)
  );
  sdo_reg16 #(.RST(`SDO_RST_DEN_LOW), .MASK(`SDO_MASK_FULL)) u_den_low (
    .aclk(aclk), .aresetn(aresetn), .we(we[3]), .wdata(wdata_r[15:0]), .wstrb(wstrb_r[1:0]), .q_r(den_low_q)
  );
  sdo_reg16 #(.RST(`SDO_RST_ZERO), .MASK(`SDO_MASK_FULL)) u_seed_high (
    .aclk(aclk), .aresetn(aresetn), .we(we[4]), .wdata(wdata_r[15:0]), .wstrb(wstrb_r[1:0]), .q_r(seed_high_q)
  );
  sdo_reg16 #(.RST(`SDO_RST_ZERO), .MASK(`SDO_MASK_FULL)) u_seed_low (
    .aclk(aclk), .aresetn(aresetn), .we(we[5]), .wdata(wdata_r[15:0]), .wstrb(wstrb_r[1:0]), .q_r(seed_low_q)
  );
  sdo_reg16 #(.RST(`SDO_RST_ZERO), .MASK(`SDO_MASK_FULL)) u_num_high (
    .aclk(aclk), .aresetn(aresetn), .we(we[6]), .wdata(wdata_r[15:0]), .wstrb(wstrb_r[1:0]), .q_r(num_high_q)
  );
  sdo_reg16 #(.RST(`SDO_RST_ZERO), .MASK(`SDO_MASK_FULL)) u_num_low (
    .aclk(aclk), .aresetn(aresetn), .we(we[7]), .wdata(wdata_r[15:0]), .wstrb(wstrb_r[1:0]), .q_r(num_low_q)
  );
  sdo_reg16 #(.RST(`SDO_RST_PWR_MOD), .MASK(`SDO_MASK_PWR_MOD)) u_pwr_mod (
    .aclk(aclk), .aresetn(aresetn), .we(we[8]), .wdata(wdata_r[15:0]), .wstrb(wstrb_r[1:0]), .q_r(pwr_mod_q)
  );
  // Source select has no defined reset; zero is used so nothing is unknown
  sdo_reg16 #(.RST(`SDO_RST_B_PWR_A_SEL), .MASK(`SDO_MASK_B_PWR_A_SEL)) u_b_pwr_a_sel (
    .aclk(aclk), .aresetn(aresetn), .we(we[9]), .wdata(wdata_r[15:0]), .wstrb(wstrb_r[1:0]), .q_r(b_pwr_a_sel_q)
  );
  // Upper N bits sit at a spare index below the low word
  sdo_reg16 #(.RST(`SDO_RST_N_HIGH), .MASK(`SDO_MASK_N_HIGH)) u_n_high (
    .aclk(aclk), .aresetn(aresetn), .we(we[10]), .wdata(wdata_r[15:0]), .wstrb(wstrb_r[1:0]), .q_r(n_high_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to the synthesizer core, one cycle behind the stored registers
  wire mod_rstn;
  reg mod_rstn_d_r;
  assign mod_rstn = pwr_mod_q[`SDO_MOD_RSTN_BIT];

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      n_divider_r <= 19'h00046;
      detector_delay_select_r <= 6'h04;
      detector_delay_quads_r <= 8'h07;
      fraction_denominator_r <= {`SDO_RST_DEN_HIGH, `SDO_RST_DEN_LOW};
      fraction_numerator_r <= 32'h00000000;
      modulator_seed_r <= 32'h00000000;
      seed_load_r <= 1'b0;
      mod_rstn_d_r <= 1'b1;
      modulator_reset_r <= 1'b0;
      modulator_order_r <= 3'h3;
      out_a_power_level_r <= 6'h1f;
      out_b_power_level_r <= 6'h1f;
      out_a_power_down_r <= 1'b0;
      out_b_power_down_r <= 1'b1;
      out_a_source_select_r <= 2'h0;
    end
    else
    begin
      n_divider_r <= {n_high_q[`SDO_N_HIGH_MSB:0], n_low_q};
      detector_delay_select_r <= pd_delay_q[`SDO_DLY_SEL_MSB:`SDO_DLY_SEL_LSB];
      // Delay in units of four VCO cycles; the core applies the final times four
      detector_delay_quads_r <= {2'b00, pd_delay_q[`SDO_DLY_SEL_MSB:`SDO_DLY_SEL_LSB]} + `SDO_DLY_BIAS;
      fraction_denominator_r <= {den_high_q, den_low_q};
      fraction_numerator_r <= {num_high_q, num_low_q};
      modulator_seed_r <= {seed_high_q, seed_low_q};
      // Seed loads as the modulator leaves reset, so the start state is repeatable
      mod_rstn_d_r <= mod_rstn;
      seed_load_r <= mod_rstn & ~mod_rstn_d_r;
      modulator_reset_r <= ~mod_rstn;
      modulator_order_r <= pwr_mod_q[`SDO_ORDER_MSB:`SDO_ORDER_LSB];
      out_a_power_level_r <= pwr_mod_q[`SDO_A_PWR_MSB:`SDO_A_PWR_LSB];
      out_b_power_level_r <= b_pwr_a_sel_q[`SDO_B_PWR_MSB:`SDO_B_PWR_LSB];
      out_a_power_down_r <= pwr_mod_q[`SDO_A_PD_BIT];
      out_b_power_down_r <= pwr_mod_q[`SDO_B_PD_BIT];
      out_a_source_select_r <= b_pwr_a_sel_q[`SDO_A_SEL_MSB:`SDO_A_SEL_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one read at a time, answer one cycle after address taken
  reg [15:0] rmux;
  wire [7:0] ridx;
  wire ar_take;
  assign ridx = word_index(s_axi_araddr);
  assign ar_take = s_axi_arvalid & s_axi_arready;

  always @*
  begin
    // Reserved and unmapped reads fall through to zero
    case (ridx)
      `SDO_IDX_N_LOW: rmux = n_low_q;
      `SDO_IDX_PD_DELAY: rmux = pd_delay_q;
      `SDO_IDX_DEN_HIGH: rmux = den_high_q;
      `SDO_IDX_DEN_LOW: rmux = den_low_q;
      `SDO_IDX_SEED_HIGH: rmux = seed_high_q;
      `SDO_IDX_SEED_LOW: rmux = seed_low_q;
      `SDO_IDX_NUM_HIGH: rmux = num_high_q;
      `SDO_IDX_NUM_LOW: rmux = num_low_q;
      `SDO_IDX_PWR_MOD: rmux = pwr_mod_q;
      `SDO_IDX_B_PWR_A_SEL: rmux = b_pwr_a_sel_q;
      `SDO_IDX_N_HIGH: rmux = n_high_q;
      default: rmux = 16'h0000;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SDO_RESP_OKAY;
    end
    else
    begin
      // Ready re-arms only after the data is accepted, so one read is in flight
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & ~ar_take;
      if (ar_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {16'h0000, rmux};
        s_axi_rresp <= is_mapped(ridx) ? `SDO_RESP_OKAY : `SDO_RESP_SLVERR;
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule // sdo_regs

// ---- dv/sdo_regs_monitor.sv ----
`timescale 1ns/10ps
module sdo_regs_monitor (
  input logic aclk,
  input logic aresetn,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic [31:0] s_axi_rdata,
  input logic [18:0] n_divider_r,
  input logic [5:0] detector_delay_select_r,
  input logic [7:0] detector_delay_quads_r,
  input logic [31:0] fraction_denominator_r,
  input logic [31:0] fraction_numerator_r,
  input logic [31:0] modulator_seed_r,
  input logic seed_load_r,
  input logic modulator_reset_r,
  input logic [2:0] modulator_order_r,
  input logic [5:0] out_a_power_level_r,
  input logic out_a_power_down_r,
  input logic out_b_power_down_r
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic wr_take;
  logic [11:0] ctrl_bus;
  logic [95:0] frac_bus;
  assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign ctrl_bus = {out_a_power_level_r, out_a_power_down_r, out_b_power_down_r, modulator_reset_r, modulator_order_r};
  assign frac_bus = {fraction_denominator_r, fraction_numerator_r, modulator_seed_r};
  ////////////////////////////////////////
  a_delay_quads_sum: assert property (detector_delay_quads_r == {2'b00, detector_delay_select_r} + 8'h03)
    else $error("delay quads not select plus three");
  a_rdata_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_write_answer: assert property (wr_take |=> ##[0:2] s_axi_bvalid)
    else $error("write not answered");
  // Core outputs may only move right after a register write lands
  a_ctrl_after_write: assert property ($changed(ctrl_bus) |-> $past(s_axi_bvalid))
    else $error("control output moved without write");
  a_frac_after_write: assert property ($changed(frac_bus) |-> $past(s_axi_bvalid))
    else $error("fraction value moved without write");
  a_ndiv_after_write: assert property ($changed(n_divider_r) |-> $past(s_axi_bvalid))
    else $error("n divider moved without write");
  a_seed_load_pulse: assert property (seed_load_r |=> !seed_load_r)
    else $error("seed load longer than one cycle");
  c_seed_load: cover property (seed_load_r);
  c_read: cover property (s_axi_arvalid && s_axi_arready);
  c_mod_reset: cover property (modulator_reset_r);
endmodule // sdo_regs_monitor

bind sdo_regs sdo_regs_monitor u_mon (.*);

// ---- dv/tb_synth_divider_output_regs.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, a); end end
module tb_synth_divider_output_regs;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, seed_load_r, modulator_reset_r, out_a_power_down_r, out_b_power_down_r;
  logic [9:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, fraction_denominator_r, fraction_numerator_r, modulator_seed_r;
  logic [3:0] s_axi_wstrb = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, out_a_source_select_r, r;
  logic [18:0] n_divider_r;
  logic [5:0] detector_delay_select_r, out_a_power_level_r, out_b_power_level_r;
  logic [7:0] detector_delay_quads_r;
  logic [2:0] modulator_order_r;
  logic [31:0] d;
  int error_cnt = 0, checks = 0, pulses = 0, p0;
  // Rows: index, reset value, write value, read-back value
  logic [55:0] rows [0:10] = '{56'h24_0046_ffff_ffff, 56'h25_0400_ffff_3f00,
    56'h26_fd51_1234_1234, 56'h27_da80_5678_5678, 56'h28_0000_9abc_9abc, 56'h29_0000_def0_def0,
    56'h2a_0000_0f0f_0f0f, 56'h2b_0000_f0f0_f0f0, 56'h2c_1fa3_ffff_3fe7, 56'h2d_001f_ffff_183f,
    56'h22_0000_ffff_0007};
  sdo_regs u_dut (.*);
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) if (seed_load_r === 1'b1) pulses <= pulses + 1;
  ////////////////////////////////////////
  task automatic rst;
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] i, input logic [15:0] v, input logic [3:0] s);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {16'h0000, v};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] i);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    r = s_axi_rresp;
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    #(25 * 20000);
    error_cnt++;
    report_and_stop;
  end
  initial
  begin
    rst;
    `CHK("reset ndiv", {19'h00046, 6'h04}, {n_divider_r, detector_delay_select_r})
    `CHK("reset quads", 8'h07, detector_delay_quads_r)
    `CHK("reset den", 32'hfd51da80, fraction_denominator_r)
    `CHK("reset num seed", 64'h0, {fraction_numerator_r, modulator_seed_r})
    `CHK("reset levels", {6'h1f, 6'h1f}, {out_a_power_level_r, out_b_power_level_r})
    `CHK("reset downs", 2'b10, {out_b_power_down_r, out_a_power_down_r})
    `CHK("reset mod", {2'b00, 3'h3}, {seed_load_r, modulator_reset_r, modulator_order_r})
    `CHK("reset source", 2'h0, out_a_source_select_r)
    $display("reset output test done");
    for (int i = 0; i < 11; i++)
    begin
      rd(rows[i][55:48]);
      `CHK("reset value", {2'b00, 16'h0000, rows[i][47:32]}, {r, d})
      wr(rows[i][55:48], rows[i][31:16], 4'h3);
      `CHK("write resp", 2'b00, r)
      rd(rows[i][55:48]);
      `CHK("read back", {16'h0000, rows[i][15:0]}, d)
    end
    $display("register table test done");
    `CHK("n divider", 19'h7ffff, n_divider_r)
    `CHK("delay quads", 8'h42, detector_delay_quads_r)
    `CHK("delay select", 6'h3f, detector_delay_select_r)
    `CHK("denominator", 32'h12345678, fraction_denominator_r)
    `CHK("seed", 32'h9abcdef0, modulator_seed_r)
    `CHK("numerator", 32'h0f0ff0f0, fraction_numerator_r)
    `CHK("ctrl level", 6'h3f, out_a_power_level_r)
    `CHK("ctrl downs", 2'b11, {out_b_power_down_r, out_a_power_down_r})
    `CHK("ctrl mod", {1'b0, 3'h7}, {modulator_reset_r, modulator_order_r})
    `CHK("out b", {2'h3, 6'h3f}, {out_a_source_select_r, out_b_power_level_r})
    $display("core output test done");
    // Every order code, with the modulator held in reset and output A at minimum power level
    for (int k = 0; k < 8; k++)
    begin
      wr(8'h2c, {13'h0000, k[2:0]}, 4'h3);
      `CHK("order", k[2:0], modulator_order_r)
    end
    `CHK("min level", 6'h00, out_a_power_level_r)
    `CHK("min downs", 3'b001, {out_b_power_down_r, out_a_power_down_r, modulator_reset_r})
    p0 = pulses;
    wr(8'h2c, 16'h0020, 4'h3);
    // Pulse counter updates by non-blocking assignment; let one edge pass
    @(posedge aclk);
    `CHK("release", {1'b0, 32'h1}, {modulator_reset_r, pulses - p0})
    $display("modulator test done");
    wr(8'h24, 16'h1234, 4'h1);
    rd(8'h24);
    `CHK("byte strobe", 32'h0000ff34, d)
    wr(8'h30, 16'hffff, 4'h3);
    `CHK("unmapped write", 2'b10, r)
    rd(8'h30);
    `CHK("unmapped read", {2'b10, 32'h0}, {r, d})
    $display("strobe and unmapped test done");
    rst;
    rd(8'h2c);
    `CHK("second reset", {16'h1fa3, 19'h46}, {d[15:0], n_divider_r})
    $display("second reset test done");
    report_and_stop;
  end
endmodule // tb_synth_divider_output_regs
